// ==== rtl/sjtp_defs.svh ====
// Constants of the SRAM test access port
`ifndef SJTP_DEFS_SVH
`define SJTP_DEFS_SVH
`define SJTP_IR_W 3
`define SJTP_ID_W 32
`define SJTP_BSR_W 109
`define SJTP_FIFO_DEPTH 32
`define SJTP_IR_EXTEST 3'h0
`define SJTP_IR_IDCODE 3'h1
`define SJTP_IR_SAMPLEZ 3'h2
`define SJTP_IR_SAMPLE 3'h4
`define SJTP_IR_CAPTURE 3'h1
`define SJTP_IR_RST `SJTP_IR_IDCODE
`define SJTP_ONES_MAX 3'h7
`define SJTP_ONES_RESET 3'h5
`endif

// ==== rtl/sjtp_pkg.sv ====
// Types of the SRAM test access port
`default_nettype none
`include "sjtp_defs.svh"
package sjtp_pkg;
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010, ST_EXIT1_DR = 16'h0020, ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080, ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400, ST_SHIFT_IR = 16'h0800, ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000, ST_EXIT2_IR = 16'h4000, ST_UPD_IR = 16'h8000
    } sjtp_state_t;
    typedef enum logic [1:0] {DR_BYP = 2'h0, DR_ID = 2'h1, DR_BSR = 2'h2} sjtp_dr_t;
    typedef struct packed {
        logic [2:0] tck;
        logic [1:0] tms;
        logic [1:0] tdi;
    } sjtp_sync_t;
    typedef struct packed {
        sjtp_sync_t sy;
        sjtp_state_t state;
        logic [`SJTP_IR_W-1:0] ir;
        logic [`SJTP_IR_W-1:0] ir_sh;
        logic [`SJTP_ID_W-1:0] id_sh;
        logic [`SJTP_BSR_W-1:0] bsr_sh;
        logic [`SJTP_BSR_W-1:0] bsr_upd;
        logic [`SJTP_BSR_W-1:0] pins_last;
        logic byp;
        logic tdo;
        logic tdo_oe_b;
        logic [2:0] ones_cnt;
    } sjtp_core_t;
endpackage : sjtp_pkg
`default_nettype wire

// ==== rtl/sjtp_port.sv ====
// Test access port with its pin-sample FIFO
`timescale 1ns/10ps
`default_nettype none
`include "sjtp_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module sjtp_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(D);
    localparam logic [AW-1:0] LAST_C = (AW)'(D - 1);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sjtp_fifo_st_t;
    sjtp_fifo_st_t s_q;
    sjtp_fifo_st_t s_d;
    logic push;
    logic pop;

    assign in_ready = s_q.cnt != DEPTH_C;
    assign out_valid = s_q.cnt != '0;
    assign out_data = s_q.mem[s_q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = (s_q.wp == LAST_C) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == LAST_C) ? '0 : s_q.rp + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : sjtp_fifo

////////////////////////////////////////////////////////////////////////////////
// Function
// - Test inputs are taken on a rising test clock and outputs change on a falling one.
// - Mode select alone steers the controller state machine.
// - The serial path is chosen by controller state and the held instruction.
// - Test data out shows the selected register's end and changes only on a falling edge.
// - Five rising edges with mode select high put the controller in logic reset.
// - Power-up reset forces the controller into logic reset without any test clock.
// - Serial data in and mode select samplers start at one after power-up reset; there is no pull-up on the inputs.
// - A test clock held low leaves the port inert.
// - Only a small subset of instructions is implemented; the rest select bypass.
// - Identification capture loads the fixed 32-bit code which shift then sends out.
// - Identification becomes the instruction at power-up and in logic reset.
// - High-impedance sample floats memory outputs except echo clocks and shifts boundary.
// - Sample capture copies the memory pin values into the boundary register.
module sjtp_port import sjtp_pkg::*; #(
    // Arbitrary identification value
    parameter logic [`SJTP_ID_W-1:0] IDCODE_VAL = 32'h0000_0001
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_b_o,
    input wire logic [`SJTP_BSR_W-1:0] pin_data_i,
    input wire logic pin_valid_i,
    output logic pin_ready_o,
    output logic ram_float_o,
    output logic echo_clock_float_o,
    output logic extest_o,
    output logic [`SJTP_BSR_W-1:0] bsr_drive_o
);
    sjtp_core_t s_q;
    sjtp_core_t s_d;
    logic tck_rise;
    logic tck_fall;
    logic tms_n;
    logic tdi_n;
    sjtp_dr_t dr_sel;
    logic dr_out;
    logic bsr_sel;
    logic cap_pop;
    logic fifo_valid;
    logic [`SJTP_BSR_W-1:0] fifo_data;
    logic [`SJTP_BSR_W-1:0] bsr_cap;

    function automatic sjtp_state_t sjtp_next(input sjtp_state_t st, input logic m);
        sjtp_state_t n;
        n = ST_TLR;
        unique case (st)
            ST_TLR: n = m ? ST_TLR : ST_IDLE;
            ST_IDLE: n = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: n = m ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: n = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: n = m ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: n = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: n = m ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: n = m ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: n = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: n = m ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: n = m ? ST_SEL_DR : ST_IDLE;
            default: n = ST_TLR;
        endcase
        return n;
    endfunction : sjtp_next

    ////////////////////////////////////////////////////////////////////////////
    // Pin sample buffer, drained one word per boundary capture
    sjtp_fifo #(.W(`SJTP_BSR_W), .D(`SJTP_FIFO_DEPTH)) u_pin_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_data(pin_data_i),
        .in_valid(pin_valid_i),
        .in_ready(pin_ready_o),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(cap_pop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the synchronised test clock
    assign tck_rise = s_q.sy.tck[1] && !s_q.sy.tck[2];
    assign tck_fall = !s_q.sy.tck[1] && s_q.sy.tck[2];
    assign tms_n = s_q.sy.tms[1];
    assign tdi_n = s_q.sy.tdi[1];

    always_comb begin
        dr_sel = DR_BYP;
        unique case (s_q.ir)
            `SJTP_IR_IDCODE: dr_sel = DR_ID;
            `SJTP_IR_EXTEST, `SJTP_IR_SAMPLEZ, `SJTP_IR_SAMPLE: dr_sel = DR_BSR;
            default: dr_sel = DR_BYP;
        endcase
    end

    assign bsr_sel = dr_sel == DR_BSR;
    assign cap_pop = tck_rise && s_q.state == ST_CAP_DR && bsr_sel && fifo_valid;
    // With no fresh sample the last one captured is taken again
    assign bsr_cap = fifo_valid ? fifo_data : s_q.pins_last;

    always_comb begin
        dr_out = s_q.byp;
        unique case (dr_sel)
            DR_ID: dr_out = s_q.id_sh[0];
            DR_BSR: dr_out = s_q.bsr_sh[0];
            default: dr_out = s_q.byp;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Controller, serial registers and output
    always_comb begin
        s_d = s_q;
        s_d.sy.tck = {s_q.sy.tck[1:0], tck_i};
        s_d.sy.tms = {s_q.sy.tms[0], tms_i};
        s_d.sy.tdi = {s_q.sy.tdi[0], tdi_i};
        if (tck_rise) begin
            case (s_q.state)
                ST_CAP_DR: begin
                    if (dr_sel == DR_ID) begin
                        s_d.id_sh = IDCODE_VAL;
                    end else if (bsr_sel) begin
                        s_d.bsr_sh = bsr_cap;
                        s_d.pins_last = bsr_cap;
                    end else begin
                        s_d.byp = 1'b0;
                    end
                end
                ST_SHIFT_DR: begin
                    if (dr_sel == DR_ID) begin
                        s_d.id_sh = {tdi_n, s_q.id_sh[`SJTP_ID_W-1:1]};
                    end else if (bsr_sel) begin
                        s_d.bsr_sh = {tdi_n, s_q.bsr_sh[`SJTP_BSR_W-1:1]};
                    end else begin
                        s_d.byp = tdi_n;
                    end
                end
                ST_UPD_DR: begin
                    if (s_q.ir == `SJTP_IR_EXTEST || s_q.ir == `SJTP_IR_SAMPLE) begin
                        s_d.bsr_upd = s_q.bsr_sh;
                    end
                end
                ST_CAP_IR: s_d.ir_sh = `SJTP_IR_CAPTURE;
                ST_SHIFT_IR: s_d.ir_sh = {tdi_n, s_q.ir_sh[`SJTP_IR_W-1:1]};
                ST_UPD_IR: s_d.ir = s_q.ir_sh;
                default: s_d.ir_sh = s_q.ir_sh;
            endcase
            s_d.state = sjtp_next(s_q.state, tms_n);
            if (s_d.state == ST_TLR) begin
                s_d.ir = `SJTP_IR_RST;
            end
            if (!tms_n) begin
                s_d.ones_cnt = 3'h0;
            end else if (s_q.ones_cnt != `SJTP_ONES_MAX) begin
                s_d.ones_cnt = s_q.ones_cnt + 3'h1;
            end
        end
        if (tck_fall) begin
            if (s_q.state == ST_SHIFT_DR) begin
                s_d.tdo = dr_out;
                s_d.tdo_oe_b = 1'b0;
            end else if (s_q.state == ST_SHIFT_IR) begin
                s_d.tdo = s_q.ir_sh[0];
                s_d.tdo_oe_b = 1'b0;
            end else begin
                s_d.tdo_oe_b = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.sy.tms <= 2'h3;
            s_q.sy.tdi <= 2'h3;
            s_q.state <= ST_TLR;
            s_q.ir <= `SJTP_IR_RST;
            s_q.tdo_oe_b <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign tdo_o = s_q.tdo;
    assign tdo_oe_b_o = s_q.tdo_oe_b;
    assign ram_float_o = s_q.ir == `SJTP_IR_SAMPLEZ;
    assign echo_clock_float_o = 1'b0;
    assign extest_o = s_q.ir == `SJTP_IR_EXTEST;
    assign bsr_drive_o = s_q.bsr_upd;

    ////////////////////////////////////////////////////////////////////////////
    AST_TDO_ON_FALL: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !$stable(s_q.tdo) || !$stable(s_q.tdo_oe_b) |-> $past(tck_fall))
        else $error("tdo changed without a falling test clock");
    AST_STATE_ON_RISE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !$stable(s_q.state) |-> $past(tck_rise))
        else $error("state changed without a rising test clock");
    AST_FIVE_ONES: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_q.ones_cnt >= `SJTP_ONES_RESET |-> s_q.state == ST_TLR)
        else $error("five high mode selects did not reach logic reset");
    AST_RESET_IDCODE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_q.state == ST_TLR |-> s_q.ir == `SJTP_IR_IDCODE)
        else $error("logic reset without identification instruction");
    AST_TMS_STEERS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        tck_rise && s_q.state == ST_TLR && !tms_n |=> s_q.state == ST_IDLE)
        else $error("low mode select did not leave logic reset");
    AST_INERT_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!s_q.sy.tck[1])[*3] |=> $stable(s_q.state) && $stable(s_q.tdo) && $stable(s_q.ir))
        else $error("port active while test clock low");
    AST_CAPTURE_ID: assert property (@(posedge ref_clk) disable iff (!rst_b)
        tck_rise && s_q.state == ST_CAP_DR && s_q.ir == `SJTP_IR_IDCODE
        |=> s_q.id_sh == IDCODE_VAL && s_q.state != ST_CAP_DR)
        else $error("identification code not captured");
    AST_CAPTURE_PINS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        tck_rise && s_q.state == ST_CAP_DR && s_q.ir == `SJTP_IR_SAMPLE
        |=> s_q.bsr_sh == $past(bsr_cap))
        else $error("pin values not captured");
    AST_TDO_ID_PATH: assert property (@(posedge ref_clk) disable iff (!rst_b)
        tck_fall && s_q.state == ST_SHIFT_DR && s_q.ir == `SJTP_IR_IDCODE
        |=> s_q.tdo == $past(s_q.id_sh[0]) && !s_q.tdo_oe_b)
        else $error("tdo not fed from identification register");
    AST_FLOAT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ram_float_o |-> s_q.ir == `SJTP_IR_SAMPLEZ && !echo_clock_float_o && !extest_o)
        else $error("float output wrong");
endmodule : sjtp_port
`default_nettype wire

// ==== testbench/sjtp_tester.sv ====
// Boundary-scan tester model driving the test link
`timescale 1ns/10ps
`default_nettype none
module sjtp_tester (
    input wire logic ref_clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_b
);
    logic last_q = 1'b0;
    logic tdo_w;
    // A released line shows the inverse of its last driven level
    assign tdo_w = tdo_oe_b ? ~last_q : tdo;
    always @(posedge ref_clk) if (!tdo_oe_b) last_q <= tdo;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One test clock: inputs change in the low phase, tdo taken just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge ref_clk);
        q = tdo_w;
        tck <= 1'b1;
        repeat (4) @(posedge ref_clk);
        tck <= 1'b0;
    endtask : step
endmodule : sjtp_tester
`default_nettype wire

// ==== testbench/sjtp_port_tb.sv ====
// Self-checking bench of the test access port
`timescale 1ns/10ps
`default_nettype none
module sjtp_port_tb;
    import sjtp_pkg::*;
    // Arbitrary identification value
    localparam logic [31:0] ID_TB = 32'h5a3c_0f01;
    logic ref_clk, rst_b, tck, tms, tdi, tdo, tdo_oe_b, pin_valid, pin_ready;
    logic ram_float, echo_float, extest;
    logic [108:0] pin_data, bsr_drive, q, pat;
    int fail_count = 0;
    int tests_run = 0;

    sjtp_port #(.IDCODE_VAL(ID_TB)) u_sjtp_port (.ref_clk(ref_clk), .rst_b(rst_b),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_b_o(tdo_oe_b),
        .pin_data_i(pin_data), .pin_valid_i(pin_valid), .pin_ready_o(pin_ready),
        .ram_float_o(ram_float), .echo_clock_float_o(echo_float), .extest_o(extest),
        .bsr_drive_o(bsr_drive));
    sjtp_tester u_sjtp_tester (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe_b(tdo_oe_b));

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [108:0] got, input logic [108:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [108:0] mkw(input logic [7:0] k);
        return {k[4:0], {26{k[3:0] ^ 4'ha}}};
    endfunction : mkw

    task automatic moves(input logic [7:0] seq, input int n);
        logic x;
        for (int i = 0; i < n; i++) begin
            u_sjtp_tester.step(seq[i], 1'b1, x);
        end
    endtask : moves

    // From idle through a data or instruction scan back to idle
    task automatic scan(input logic ir, input int n, input logic [108:0] din);
        q = '0;
        moves(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            u_sjtp_tester.step(i == n - 1, din[i], q[i]);
        end
        moves(8'h01, 2);
    endtask : scan

    task automatic load_ir(input logic [2:0] code);
        scan(1'b1, 3, {106'h0, code});
        chk(q, 109'h1);
    endtask : load_ir

    task automatic push(input logic [108:0] w, input logic exp_ready);
        @(posedge ref_clk);
        pin_valid <= 1'b1;
        pin_data <= w;
        @(negedge ref_clk);
        chk({108'h0, pin_ready}, {108'h0, exp_ready});
        @(posedge ref_clk);
        pin_valid <= 1'b0;
    endtask : push

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({104'h0, tdo_oe_b, ram_float, extest, echo_float, pin_ready}, 109'h11);
        chk(bsr_drive, '0);
    endtask : t_reset

    task automatic t_idcode();
        scan(1'b0, 32, '0);
        chk(q, {77'h0, ID_TB});
    endtask : t_idcode

    task automatic t_bypass();
        load_ir(3'h3);
        scan(1'b0, 8, 109'hb4);
        chk(q, 109'h68);
    endtask : t_bypass

    task automatic t_modes();
        logic [2:0] c;
        for (int i = 0; i < 3; i++) begin
            c = (i == 0) ? 3'h0 : (i == 1) ? 3'h2 : 3'h4;
            load_ir(c);
            chk({106'h0, extest, ram_float, echo_float}, {106'h0, c == 3'h0, c == 3'h2, 1'b0});
        end
        load_ir(3'h2);
        moves(8'h1f, 5);
        chk({108'h0, ram_float}, '0);
        moves(8'h00, 1);
        t_idcode();
    endtask : t_modes

    task automatic t_fifo();
        for (int k = 0; k < 33; k++) begin
            push(mkw(k[7:0]), k < 32);
        end
        load_ir(3'h4);
        for (int k = 0; k < 31; k++) begin
            moves(8'h0d, 5);
        end
        chk({108'h0, pin_ready}, 109'h1);
        pat = {mkw(8'h5c)};
        scan(1'b0, 109, pat);
        chk(q, mkw(8'd31));
        chk(bsr_drive, pat);
        scan(1'b0, 109, ~pat);
        chk(q, mkw(8'd31));
        chk(bsr_drive, ~pat);
    endtask : t_fifo

    task automatic t_inert();
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            u_sjtp_tester.tms <= i[0];
            u_sjtp_tester.tdi <= i[1];
        end
        repeat (4) @(posedge ref_clk);
        chk({106'h0, tdo_oe_b, extest, ram_float}, 109'h4);
        chk(bsr_drive, ~pat);
    endtask : t_inert

    // Boundary path under high-impedance sample, then a power-up reset in mid-run
    task automatic t_por();
        load_ir(3'h2);
        scan(1'b0, 109, pat);
        chk(q, mkw(8'd31));
        chk(bsr_drive, ~pat);
        chk({108'h0, ram_float}, 109'h1);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({104'h0, tdo_oe_b, ram_float, extest, echo_float, pin_ready}, 109'h11);
        chk(bsr_drive, '0);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        moves(8'h00, 1);
        t_idcode();
    endtask : t_por

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        #3000000;
        fail_count++;
        conclude();
    end

    initial begin
        rst_b = 1'b0;
        pin_valid = 1'b0;
        pin_data = '0;
        repeat (6) @(posedge ref_clk);
        t_reset();
        rst_b <= 1'b1;
        @(posedge ref_clk);
        moves(8'h00, 1);
        t_idcode();
        t_bypass();
        t_modes();
        t_fifo();
        t_inert();
        t_por();
        conclude();
    end
endmodule : sjtp_port_tb
`default_nettype wire
